//--- rtl/pafs_pkg.sv
// constants shared by the alternate function select block
package pafs_pkg;
	localparam int P0_W       = 7;
	localparam int P1_W       = 1;
	localparam int P3_W       = 10;
	localparam int P4_W       = 3;
	localparam int P5_W       = 3;
	// pin positions
	localparam int P0_NMI     = 2;
	localparam int P0_INT0    = 3;
	localparam int P0_INT1    = 4;
	localparam int P0_INT2    = 5;
	localparam int P0_INT3    = 6;
	localparam int P1_DAC     = 0;
	localparam int P3_TXD     = 0;
	localparam int P3_RXD     = 1;
	localparam int P3_TP0     = 2;
	localparam int P3_TP1     = 4;
	localparam int P3_I2C0    = 9;
	localparam int P4_DIN     = 0;
	localparam int P4_DOUT    = 1;
	localparam int P4_CLK     = 2;
	localparam int P5_DBG     = 2;
	// selection encodings {expansion, function}
	localparam logic [1:0] SEL_CAP  = 2'h1;
	localparam logic [1:0] SEL_TOUT = 2'h2;
	localparam logic [1:0] SEL_RTP  = 2'h3;
	localparam logic       FN_FIRST = 1'h0;
	localparam logic       FN_SECOND = 1'h1;
	localparam logic       MODE_ALT = 1'h1;
	localparam logic       DIR_IN   = 1'h1;
	localparam logic       OD_ON    = 1'h1;
	localparam logic       DBG_ON   = 1'h1;
	typedef enum logic [1:0] {
		PAFS_GPIO  = 2'b00,
		PAFS_ALT   = 2'b01,
		PAFS_DEBUG = 2'b10
	} pafs_pinmode_t;
endpackage

//--- rtl/pafs_pin_if.sv
// per-port bundle between the selector and pad cells
`timescale 1ns/100ps
interface pafs_pin_if #(parameter int W = 1);
	logic [W-1:0] pin_in;
	logic [W-1:0] alt_out;
	logic [W-1:0] alt_oe;
	logic [W-1:0] alt_sel;
	logic [W-1:0] od_sel;
	logic [W-1:0] gp_data;
	logic [W-1:0] gp_dir;
	logic [W-1:0] pin_out;
	logic [W-1:0] pin_oe;
	logic [W-1:0] alt_in;
	logic [W-1:0] gp_in;
	modport sel (output alt_out, alt_oe, alt_sel, od_sel, gp_data, gp_dir,
		input pin_in, pin_out, pin_oe, alt_in, gp_in);
	modport pad (input alt_out, alt_oe, alt_sel, od_sel, gp_data, gp_dir,
		pin_in, output pin_out, pin_oe, alt_in, gp_in);
endinterface

//--- rtl/pafs_sync3.sv
// three stage pin synchroniser, change accepted when stages two and three agree
`timescale 1ns/100ps
module pafs_sync3 #(parameter int W = 1) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	always_ff @(posedge clk) begin
		if (reset) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (reset)
					q[i] <= 1'b0;
				else if (s2_r[i] == s3_r[i])
					q[i] <= s3_r[i];
			end
		end
	endgenerate
endmodule

//--- rtl/pafs_pad.sv
// pad path: general port or alternate drive, open drain, hysteresis gating
`timescale 1ns/100ps
module pafs_pad #(parameter int W = 1) (
	input wire logic clk,
	input wire logic reset,
	pafs_pin_if.pad  p
);
	logic [W-1:0] in_s;

	pafs_sync3 #(.W(W)) u_sync (
		.clk   (clk),
		.reset (reset),
		.d     (p.pin_in),
		.q     (in_s)
	);

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_pin
			// alternate path ignores data and direction
			always_comb begin
				if (p.alt_sel[i]) begin
					p.pin_out[i] = p.od_sel[i] ? 1'b0 : p.alt_out[i];
					p.pin_oe[i]  = p.od_sel[i] ?
						(p.alt_oe[i] & ~p.alt_out[i]) : p.alt_oe[i];
				end else begin
					p.pin_out[i] = p.gp_data[i];
					p.pin_oe[i]  = ~p.gp_dir[i];
				end
			end
			// filtered input only on alternate path
			assign p.alt_in[i] = p.alt_sel[i] ? in_s[i] : 1'b0;
			assign p.gp_in[i]  = p.alt_sel[i] ? 1'b0 : p.pin_in[i];
		end
	endgenerate
endmodule

//--- rtl/pafs_top.sv
// alternate function selection for ports 0,1,3,4 and 5 bits 0-2
// ----------------------------------------------------------------
// Functional notes
// - mode bit 1 routes pin to alternate function, data and direction ignored
// - port 0 bit 2 is non-maskable interrupt in alternate mode
// - port 0 bit 3: function 0 ext interrupt 0, 1 a/d trigger
// - port 0 bits 4-6 are ext interrupts 1-3 in alternate mode
// - debug mode makes port 0 bit 5 the debug reset input
// - port 1 bit 0 gives dac output 0 when direction is input
// - port 3 bit 0 transmits serial 0, bit 1 receives or interrupt 7
// - port 3 bit 2 with expansion 0: function 0 baud clock and capture, 1 timer out
// - port 3 bit 4: function 0 timer p1 capture, 1 timer p1 out
// - port 3 bit 9: function 0 serial 2 receive, 1 i2c 0 clock
// - port 4 bit 0: function 0 csi data in, 1 i2c 1 data
// - port 4 bit 1: function 0 csi data out, 1 i2c 1 clock
// - port 4 bit 2 carries bidirectional csi clock in alternate mode
// - port 5 pair 01 capture/key, 10 timer out, 11 realtime bit
// - debug mode makes port 5 bit 2 the debug serial input
// - hysteresis only on alternate input path
// ----------------------------------------------------------------
`timescale 1ns/100ps
module pafs_top
	import pafs_pkg::*;
(
	input  wire logic                        clk,
	input  wire logic                        reset,
	input  wire logic                        onchip_debug_mode_bit,
	input  wire logic [pafs_pkg::P0_W-1:0]   p0_port_mode_control,
	input  wire logic [pafs_pkg::P0_W-1:0]   p0_function_control,
	input  wire logic [pafs_pkg::P0_W-1:0]   p0_data,
	input  wire logic [pafs_pkg::P0_W-1:0]   p0_port_direction,
	input  wire logic [pafs_pkg::P0_W-1:0]   p0_pin_in,
	output logic      [pafs_pkg::P0_W-1:0]   p0_pin_out,
	output logic      [pafs_pkg::P0_W-1:0]   p0_pin_oe,
	output logic      [pafs_pkg::P0_W-1:0]   p0_gp_in,
	input  wire logic [pafs_pkg::P1_W-1:0]   p1_data,
	input  wire logic [pafs_pkg::P1_W-1:0]   p1_port_direction,
	input  wire logic [pafs_pkg::P1_W-1:0]   p1_pin_in,
	output logic      [pafs_pkg::P1_W-1:0]   p1_pin_out,
	output logic      [pafs_pkg::P1_W-1:0]   p1_pin_oe,
	output logic      [pafs_pkg::P1_W-1:0]   p1_gp_in,
	output logic                             dac_out_0_enable,
	input  wire logic [pafs_pkg::P3_W-1:0]   p3_port_mode_control,
	input  wire logic [pafs_pkg::P3_W-1:0]   p3_function_control,
	input  wire logic [pafs_pkg::P3_W-1:0]   p3_function_control_expansion,
	input  wire logic [pafs_pkg::P3_W-1:0]   p3_open_drain_select,
	input  wire logic [pafs_pkg::P3_W-1:0]   p3_data,
	input  wire logic [pafs_pkg::P3_W-1:0]   p3_port_direction,
	input  wire logic [pafs_pkg::P3_W-1:0]   p3_pin_in,
	output logic      [pafs_pkg::P3_W-1:0]   p3_pin_out,
	output logic      [pafs_pkg::P3_W-1:0]   p3_pin_oe,
	output logic      [pafs_pkg::P3_W-1:0]   p3_gp_in,
	input  wire logic [pafs_pkg::P4_W-1:0]   p4_port_mode_control,
	input  wire logic [pafs_pkg::P4_W-1:0]   p4_function_control,
	input  wire logic [pafs_pkg::P4_W-1:0]   p4_open_drain_select,
	input  wire logic [pafs_pkg::P4_W-1:0]   p4_data,
	input  wire logic [pafs_pkg::P4_W-1:0]   p4_port_direction,
	input  wire logic [pafs_pkg::P4_W-1:0]   p4_pin_in,
	output logic      [pafs_pkg::P4_W-1:0]   p4_pin_out,
	output logic      [pafs_pkg::P4_W-1:0]   p4_pin_oe,
	output logic      [pafs_pkg::P4_W-1:0]   p4_gp_in,
	input  wire logic [pafs_pkg::P5_W-1:0]   p5_port_mode_control,
	input  wire logic [pafs_pkg::P5_W-1:0]   p5_function_control,
	input  wire logic [pafs_pkg::P5_W-1:0]   p5_function_control_expansion,
	input  wire logic [pafs_pkg::P5_W-1:0]   p5_data,
	input  wire logic [pafs_pkg::P5_W-1:0]   p5_port_direction,
	input  wire logic [pafs_pkg::P5_W-1:0]   p5_pin_in,
	output logic      [pafs_pkg::P5_W-1:0]   p5_pin_out,
	output logic      [pafs_pkg::P5_W-1:0]   p5_pin_oe,
	output logic      [pafs_pkg::P5_W-1:0]   p5_gp_in,
	output logic                             nmi_in,
	output logic [3:0]                       ext_interrupt_in,
	output logic                             ad_external_trigger,
	output logic                             debug_reset_in,
	output logic                             debug_serial_in,
	input  wire logic                        serial0_transmit,
	output logic                             serial0_receive,
	output logic                             ext_interrupt_7,
	output logic                             serial0_baud_clock,
	output logic                             timer_p0_capture_in,
	input  wire logic                        timer_p0_out,
	output logic                             timer_p1_capture_in,
	input  wire logic                        timer_p1_out,
	output logic                             serial2_receive,
	input  wire logic                        i2c0_clock_out,
	output logic                             i2c0_clock_in,
	input  wire logic                        i2c1_data_out,
	output logic                             i2c1_data_in,
	input  wire logic                        i2c1_clock_out,
	output logic                             i2c1_clock_in,
	output logic                             csi0_data_in,
	input  wire logic                        csi0_data_out,
	input  wire logic                        csi0_clock_out,
	input  wire logic                        csi0_clock_oe,
	output logic                             csi0_clock_in,
	output logic [pafs_pkg::P5_W-1:0]        timer_q0_capture_in,
	output logic [pafs_pkg::P5_W-1:0]        key_return_in,
	input  wire logic [pafs_pkg::P5_W-1:0]   timer_q0_out,
	input  wire logic [pafs_pkg::P5_W-1:0]   realtime_output_bit
);
	import pafs_pkg::*;

	pafs_pin_if #(.W(P0_W)) b0 ();
	pafs_pin_if #(.W(P1_W)) b1 ();
	pafs_pin_if #(.W(P3_W)) b3 ();
	pafs_pin_if #(.W(P4_W)) b4 ();
	pafs_pin_if #(.W(P5_W)) b5 ();

	logic dbg_r;

	// ----------------------------------------------------------------
	// debug mode capture
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset)
			dbg_r <= 1'b0;
		else
			dbg_r <= onchip_debug_mode_bit;
	end

	// ----------------------------------------------------------------
	// port 0
	// ----------------------------------------------------------------
	always_comb begin
		b0.alt_sel = p0_port_mode_control;
		// debug claims the reset input pin
		b0.alt_sel[P0_INT2] = p0_port_mode_control[P0_INT2] |
			(dbg_r == DBG_ON);
		b0.alt_out = '0;
		b0.alt_oe  = '0;
		b0.od_sel  = '0;
	end
	assign b0.gp_data = p0_data;
	assign b0.gp_dir  = p0_port_direction;
	assign b0.pin_in  = p0_pin_in;
	assign p0_pin_out = b0.pin_out;
	assign p0_pin_oe  = b0.pin_oe;
	assign p0_gp_in   = b0.gp_in;

	assign nmi_in = b0.alt_in[P0_NMI];
	assign ext_interrupt_in[0] = (p0_function_control[P0_INT0] ==
		FN_FIRST) ? b0.alt_in[P0_INT0] : 1'b0;
	assign ad_external_trigger = (p0_function_control[P0_INT0] ==
		FN_SECOND) ? b0.alt_in[P0_INT0] : 1'b0;
	// interrupts 1 to 3, debug takes interrupt 2 away
	assign ext_interrupt_in[1] = b0.alt_in[P0_INT1];
	assign ext_interrupt_in[2] = (dbg_r == DBG_ON) ? 1'b0 :
		b0.alt_in[P0_INT2];
	assign ext_interrupt_in[3] = b0.alt_in[P0_INT3];
	assign debug_reset_in = (dbg_r == DBG_ON) ? b0.alt_in[P0_INT2] : 1'b0;

	// ----------------------------------------------------------------
	// port 1
	// ----------------------------------------------------------------
	assign b1.alt_sel = '0;
	assign b1.alt_out = '0;
	assign b1.alt_oe  = '0;
	assign b1.od_sel  = '0;
	assign b1.gp_data = p1_data;
	assign b1.gp_dir  = p1_port_direction;
	assign b1.pin_in  = p1_pin_in;
	assign p1_pin_out = b1.pin_out;
	assign p1_pin_oe  = b1.pin_oe;
	assign p1_gp_in   = b1.gp_in;
	// analog output while direction is input, digital driver off
	assign dac_out_0_enable = (p1_port_direction[P1_DAC] == DIR_IN);

	// ----------------------------------------------------------------
	// port 3
	// ----------------------------------------------------------------
	always_comb begin
		b3.alt_out = '0;
		b3.alt_oe  = '0;
		b3.alt_out[P3_TXD] = serial0_transmit;
		b3.alt_oe[P3_TXD]  = 1'b1;
		// timer p0 output only with expansion 0 and function 1
		if (p3_function_control_expansion[P3_TP0] == FN_FIRST &&
				p3_function_control[P3_TP0] == FN_SECOND) begin
			b3.alt_out[P3_TP0] = timer_p0_out;
			b3.alt_oe[P3_TP0]  = 1'b1;
		end
		if (p3_function_control[P3_TP1] == FN_SECOND) begin
			b3.alt_out[P3_TP1] = timer_p1_out;
			b3.alt_oe[P3_TP1]  = 1'b1;
		end
		if (p3_function_control[P3_I2C0] == FN_SECOND) begin
			b3.alt_out[P3_I2C0] = i2c0_clock_out;
			b3.alt_oe[P3_I2C0]  = 1'b1;
		end
	end
	assign b3.alt_sel = p3_port_mode_control;
	assign b3.od_sel  = p3_open_drain_select;
	assign b3.gp_data = p3_data;
	assign b3.gp_dir  = p3_port_direction;
	assign b3.pin_in  = p3_pin_in;
	assign p3_pin_out = b3.pin_out;
	assign p3_pin_oe  = b3.pin_oe;
	assign p3_gp_in   = b3.gp_in;

	// shared receive pin, software masks the unused side
	assign serial0_receive = b3.alt_in[P3_RXD];
	assign ext_interrupt_7 = b3.alt_in[P3_RXD];
	// baud clock and capture share the input
	assign serial0_baud_clock = (p3_function_control[P3_TP0] == FN_FIRST &&
		p3_function_control_expansion[P3_TP0] == FN_FIRST) ?
		b3.alt_in[P3_TP0] : 1'b0;
	assign timer_p0_capture_in = serial0_baud_clock;
	assign timer_p1_capture_in = (p3_function_control[P3_TP1] ==
		FN_FIRST) ? b3.alt_in[P3_TP1] : 1'b0;
	assign serial2_receive = (p3_function_control[P3_I2C0] == FN_FIRST) ?
		b3.alt_in[P3_I2C0] : 1'b0;
	assign i2c0_clock_in = (p3_function_control[P3_I2C0] == FN_SECOND) ?
		b3.alt_in[P3_I2C0] : 1'b0;

	// ----------------------------------------------------------------
	// port 4
	// ----------------------------------------------------------------
	always_comb begin
		b4.alt_out = '0;
		b4.alt_oe  = '0;
		if (p4_function_control[P4_DIN] == FN_SECOND) begin
			b4.alt_out[P4_DIN] = i2c1_data_out;
			b4.alt_oe[P4_DIN]  = 1'b1;
		end
		// csi data or i2c clock drive
		b4.alt_out[P4_DOUT] = (p4_function_control[P4_DOUT] == FN_FIRST) ?
			csi0_data_out : i2c1_clock_out;
		b4.alt_oe[P4_DOUT] = 1'b1;
		b4.alt_out[P4_CLK] = csi0_clock_out;
		b4.alt_oe[P4_CLK]  = csi0_clock_oe;
	end
	assign b4.alt_sel = p4_port_mode_control;
	assign b4.od_sel  = p4_open_drain_select;
	assign b4.gp_data = p4_data;
	assign b4.gp_dir  = p4_port_direction;
	assign b4.pin_in  = p4_pin_in;
	assign p4_pin_out = b4.pin_out;
	assign p4_pin_oe  = b4.pin_oe;
	assign p4_gp_in   = b4.gp_in;

	assign csi0_data_in = (p4_function_control[P4_DIN] == FN_FIRST) ?
		b4.alt_in[P4_DIN] : 1'b0;
	assign i2c1_data_in = (p4_function_control[P4_DIN] == FN_SECOND) ?
		b4.alt_in[P4_DIN] : 1'b0;
	assign i2c1_clock_in = (p4_function_control[P4_DOUT] == FN_SECOND) ?
		b4.alt_in[P4_DOUT] : 1'b0;
	assign csi0_clock_in = b4.alt_in[P4_CLK];

	// ----------------------------------------------------------------
	// port 5
	// ----------------------------------------------------------------
	logic [P5_W-1:0] p5_sel;
	always_comb begin
		p5_sel = p5_port_mode_control;
		if (dbg_r == DBG_ON)
			p5_sel[P5_DBG] = 1'b1;
	end
	assign b5.alt_sel = p5_sel;
	assign b5.od_sel  = '0;
	assign b5.gp_data = p5_data;
	assign b5.gp_dir  = p5_port_direction;
	assign b5.pin_in  = p5_pin_in;
	assign p5_pin_out = b5.pin_out;
	assign p5_pin_oe  = b5.pin_oe;
	assign p5_gp_in   = b5.gp_in;

	genvar k;
	generate
		for (k = 0; k < P5_W; k++) begin : g_p5
			logic [1:0] code;
			logic       dbg_pin;
			assign code = {p5_function_control_expansion[k],
				p5_function_control[k]};
			assign dbg_pin = (k == P5_DBG) && (dbg_r == DBG_ON);
			always_comb begin
				b5.alt_out[k] = 1'b0;
				b5.alt_oe[k]  = 1'b0;
				if (!dbg_pin) begin
					case (code)
					SEL_TOUT: begin
						b5.alt_out[k] = timer_q0_out[k];
						b5.alt_oe[k]  = 1'b1;
					end
					SEL_RTP: begin
						b5.alt_out[k] = realtime_output_bit[k];
						b5.alt_oe[k]  = 1'b1;
					end
					default: begin
						b5.alt_out[k] = 1'b0;
						b5.alt_oe[k]  = 1'b0;
					end
					endcase
				end
			end
			// capture and key share the pin, software masks
			assign timer_q0_capture_in[k] = (!dbg_pin && code == SEL_CAP) ?
				b5.alt_in[k] : 1'b0;
			assign key_return_in[k] = timer_q0_capture_in[k];
		end
	endgenerate
	assign debug_serial_in = (dbg_r == DBG_ON) ? b5.alt_in[P5_DBG] : 1'b0;

	// ----------------------------------------------------------------
	// pads
	// ----------------------------------------------------------------
	pafs_pad #(.W(P0_W)) u_pad0 (.clk(clk), .reset(reset), .p(b0));
	pafs_pad #(.W(P1_W)) u_pad1 (.clk(clk), .reset(reset), .p(b1));
	pafs_pad #(.W(P3_W)) u_pad3 (.clk(clk), .reset(reset), .p(b3));
	pafs_pad #(.W(P4_W)) u_pad4 (.clk(clk), .reset(reset), .p(b4));
	pafs_pad #(.W(P5_W)) u_pad5 (.clk(clk), .reset(reset), .p(b5));

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// open drain pins are left out: they drive low only
	a_alt_ignores_dir: assert property (@(posedge clk)
		disable iff (reset) (p3_port_mode_control[P3_TXD] &&
		!p3_open_drain_select[P3_TXD]) |-> p3_pin_out[P3_TXD] ==
		serial0_transmit && p3_pin_oe[P3_TXD])
		else $error("alternate pin follows direction");
	a_gpio_mode: assert property (@(posedge clk)
		disable iff (reset) !p4_port_mode_control[P4_CLK] |->
		p4_pin_out[P4_CLK] == p4_data[P4_CLK] &&
		p4_pin_oe[P4_CLK] == !p4_port_direction[P4_CLK])
		else $error("general port path wrong");
	a_adtrig_sel: assert property (@(posedge clk)
		disable iff (reset)
		!p0_function_control[P0_INT0] |-> !ad_external_trigger)
		else $error("trigger active with function 0");
	a_dbg_reset: assert property (@(posedge clk)
		disable iff (reset) !dbg_r |-> !debug_reset_in && !debug_serial_in)
		else $error("debug input outside debug mode");
	a_timer_p0_out: assert property (@(posedge clk)
		disable iff (reset) (p3_port_mode_control[P3_TP0] &&
		p3_function_control[P3_TP0] && !p3_open_drain_select[P3_TP0] &&
		!p3_function_control_expansion[P3_TP0]) |->
		p3_pin_out[P3_TP0] == timer_p0_out)
		else $error("timer p0 output not routed");
	a_i2c_open_drain: assert property (@(posedge clk)
		disable iff (reset) (p3_port_mode_control[P3_I2C0] &&
		p3_open_drain_select[P3_I2C0] && i2c0_clock_out) |->
		!p3_pin_oe[P3_I2C0])
		else $error("open drain drives high");
	a_rtp_sel: assert property (@(posedge clk)
		disable iff (reset) (!dbg_r && p5_port_mode_control[P5_DBG] &&
		p5_function_control[P5_DBG] &&
		p5_function_control_expansion[P5_DBG]) |->
		p5_pin_out[P5_DBG] == realtime_output_bit[P5_DBG])
		else $error("realtime bit not routed");
	a_dac_enable: assert property (@(posedge clk)
		disable iff (reset)
		dac_out_0_enable == p1_port_direction[P1_DAC])
		else $error("dac enable mismatch");
	a_hyst_path: assert property (@(posedge clk)
		disable iff (reset)
		!p0_port_mode_control[P0_INT1] |-> !ext_interrupt_in[1])
		else $error("alternate input live in port mode");
endmodule

//--- bench/pafs_periph_model.sv
// peripheral side model: drives the peripheral outputs into the selector
`timescale 1ns/100ps
module pafs_periph_model
	import pafs_pkg::*;
(
	input  wire logic [14:0]               lvl,
	output logic                           serial0_transmit,
	output logic                           timer_p0_out,
	output logic                           timer_p1_out,
	output logic                           i2c0_clock_out,
	output logic                           i2c1_data_out,
	output logic                           i2c1_clock_out,
	output logic                           csi0_data_out,
	output logic                           csi0_clock_out,
	output logic                           csi0_clock_oe,
	output logic [pafs_pkg::P5_W-1:0]      timer_q0_out,
	output logic [pafs_pkg::P5_W-1:0]      realtime_output_bit
);
	// levels from lvl, csi0_clock_oe included; the bench sets that enable in the port 4 test
	assign {realtime_output_bit, timer_q0_out, csi0_clock_oe,
		csi0_clock_out, csi0_data_out, i2c1_clock_out, i2c1_data_out,
		i2c0_clock_out, timer_p1_out, timer_p0_out,
		serial0_transmit} = lvl;
endmodule

//--- bench/test_port_alternate_function_select.sv
// self-checking bench for the alternate function selector
`timescale 1ns/100ps
module test_port_alternate_function_select;
	import pafs_pkg::*;
	logic clk = 0, reset = 1, onchip_debug_mode_bit = 0;
	logic [14:0] lvl = '0;
	logic [P0_W-1:0] p0_port_mode_control = '0, p0_function_control = '0;
	logic [P0_W-1:0] p0_data = '0, p0_port_direction = '0, p0_pin_in = '0;
	logic [P0_W-1:0] p0_pin_out, p0_pin_oe, p0_gp_in;
	logic [P1_W-1:0] p1_data = '0, p1_port_direction = '0, p1_pin_in = '0;
	logic [P1_W-1:0] p1_pin_out, p1_pin_oe, p1_gp_in;
	logic [P3_W-1:0] p3_port_mode_control = '0, p3_function_control = '0;
	logic [P3_W-1:0] p3_function_control_expansion = '0;
	logic [P3_W-1:0] p3_open_drain_select = '0, p3_data = '0;
	logic [P3_W-1:0] p3_port_direction = '0, p3_pin_in = '0;
	logic [P3_W-1:0] p3_pin_out, p3_pin_oe, p3_gp_in;
	logic [P4_W-1:0] p4_port_mode_control = '0, p4_function_control = '0;
	logic [P4_W-1:0] p4_open_drain_select = '0, p4_data = '0;
	logic [P4_W-1:0] p4_port_direction = '0, p4_pin_in = '0;
	logic [P4_W-1:0] p4_pin_out, p4_pin_oe, p4_gp_in;
	logic [P5_W-1:0] p5_port_mode_control = '0, p5_function_control = '0;
	logic [P5_W-1:0] p5_function_control_expansion = '0, p5_data = '0;
	logic [P5_W-1:0] p5_port_direction = '0, p5_pin_in = '0;
	logic [P5_W-1:0] p5_pin_out, p5_pin_oe, p5_gp_in;
	logic [P5_W-1:0] timer_q0_capture_in, key_return_in;
	logic [P5_W-1:0] timer_q0_out, realtime_output_bit;
	logic [3:0] ext_interrupt_in;
	logic dac_out_0_enable, nmi_in, ad_external_trigger, debug_reset_in;
	logic debug_serial_in, serial0_receive, ext_interrupt_7;
	logic serial0_baud_clock, timer_p0_capture_in, timer_p1_capture_in;
	logic serial2_receive, i2c0_clock_in, i2c1_data_in, i2c1_clock_in;
	logic csi0_data_in, csi0_clock_in, serial0_transmit, timer_p0_out;
	logic timer_p1_out, i2c0_clock_out, i2c1_data_out, i2c1_clock_out;
	logic csi0_data_out, csi0_clock_out, csi0_clock_oe;
	int miscompares = 0, checks = 0, cyc = 0;

	pafs_top dut_u (.*);
	pafs_periph_model peri_u (.*);

	initial begin
		forever #4 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string n, input logic [9:0] s, e);
		checks++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	// four edges cover the synchroniser latency
	task automatic settle(input int n = 4);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic conclude();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			conclude();
		end
	end
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_gpio();
		p3_data = 10'h2a5;
		p3_port_direction = 10'h0f0;
		p3_pin_in = 10'h3c3;
		p0_pin_in = 7'h7f;
		settle();
		chk("p3 out", p3_pin_out, 10'h2a5);
		chk("p3 oe", p3_pin_oe, 10'h30f);
		chk("p3 gp", p3_gp_in, 10'h3c3);
		chk("rx off", serial0_receive, 1'h0);
		chk("nmi off", nmi_in, 1'h0);
		$display("test gpio done");
	endtask
	task automatic t_p0();
		p0_port_mode_control = 7'h7c;
		p0_data = 7'h7f;
		p0_pin_in = 7'h7c;
		settle();
		chk("nmi", nmi_in, 1'h1);
		chk("ext int", ext_interrupt_in, 4'hf);
		chk("adtrig", ad_external_trigger, 1'h0);
		chk("p0 oe", p0_pin_oe & 7'h7c, 7'h00);
		chk("p0 out", p0_pin_out & 7'h7c, 7'h00);
		chk("p0 gp", p0_gp_in & 7'h7c, 7'h00);
		p0_function_control = 7'h08;
		settle(1);
		chk("adtrig sel", ad_external_trigger, 1'h1);
		chk("int0 off", ext_interrupt_in[0], 1'h0);
		p0_port_mode_control = '0;
		$display("test port0 done");
	endtask
	task automatic t_dbg();
		onchip_debug_mode_bit = 1;
		p0_pin_in = 7'h20;
		p5_pin_in = 3'h4;
		p5_data = 3'h7;
		settle(5);
		chk("dbg rst", debug_reset_in, 1'h1);
		chk("dbg rst oe", p0_pin_oe[5], 1'h0);
		chk("dbg ser", debug_serial_in, 1'h1);
		chk("dbg ser oe", p5_pin_oe[2], 1'h0);
		onchip_debug_mode_bit = 0;
		$display("test debug done");
	endtask
	task automatic t_p3();
		// both consumers see the pin; the unused one is masked elsewhere
		p3_port_mode_control = 10'h217;
		p3_open_drain_select = 10'h200;
		lvl = 15'h0001;
		p3_pin_in = 10'h000;
		settle();
		// a one cycle pulse from a quiet line must not get through
		p3_pin_in = 10'h002;
		settle(1);
		p3_pin_in = 10'h000;
		settle(3);
		chk("glitch", serial0_receive, 1'h0);
		p3_pin_in = 10'h216;
		settle();
		chk("txd", {p3_pin_oe[0], p3_pin_out[0]}, 2'h3);
		chk("rxd", serial0_receive, 1'h1);
		chk("int7", ext_interrupt_7, 1'h1);
		chk("baud", serial0_baud_clock, 1'h1);
		chk("cap p0", timer_p0_capture_in, 1'h1);
		chk("cap p1", timer_p1_capture_in, 1'h1);
		chk("rx2", serial2_receive, 1'h1);
		p3_function_control = 10'h214;
		lvl = 15'h0002;
		settle(1);
		chk("top p0", {p3_pin_oe[2], p3_pin_out[2]}, 2'h3);
		chk("cap p0 off", timer_p0_capture_in, 1'h0);
		chk("top p1", {p3_pin_oe[4], p3_pin_out[4]}, 2'h2);
		chk("scl0 low", {p3_pin_oe[9], p3_pin_out[9]}, 2'h2);
		chk("scl0 in", i2c0_clock_in, 1'h1);
		chk("rx2 off", serial2_receive, 1'h0);
		lvl = 15'h0008;
		settle(1);
		chk("scl0 rel", p3_pin_oe[9], 1'h0);
		$display("test port3 done");
	endtask
	task automatic t_p4();
		p4_port_mode_control = 3'h7;
		p4_pin_in = 3'h5;
		lvl = 15'h01c0;
		settle();
		chk("csi in", csi0_data_in, 1'h1);
		chk("csi out", {p4_pin_oe[1], p4_pin_out[1]}, 2'h3);
		chk("csi clk", {p4_pin_oe[2], p4_pin_out[2]}, 2'h3);
		chk("csi clk in", csi0_clock_in, 1'h1);
		chk("p4 gp", p4_gp_in, 3'h0);
		p4_function_control = 3'h3;
		p4_open_drain_select = 3'h3;
		p4_pin_in = 3'h7;
		lvl = 15'h0020;
		settle();
		chk("i2c1 oe", p4_pin_oe[1:0], 2'h1);
		chk("sda1 in", i2c1_data_in, 1'h1);
		chk("scl1 in", i2c1_clock_in, 1'h1);
		chk("csi in off", csi0_data_in, 1'h0);
		$display("test port4 done");
	endtask
	task automatic t_p5();
		// key return mode and trigger enables are left to software
		p5_port_mode_control = 3'h7;
		p5_function_control_expansion = 3'h6;
		p5_function_control = 3'h5;
		p5_pin_in = 3'h7;
		lvl = 15'h4e00;
		settle();
		chk("tq cap", timer_q0_capture_in, 3'h1);
		chk("key", key_return_in, 3'h1);
		chk("p5 oe", p5_pin_oe, 3'h6);
		chk("p5 out", p5_pin_out, 3'h6);
		chk("p5 gp", p5_gp_in, 3'h0);
		p1_port_direction = 1'h1;
		settle(1);
		chk("dac on", dac_out_0_enable, 1'h1);
		chk("p1 oe", p1_pin_oe, 1'h0);
		p1_port_direction = 1'h0;
		settle(1);
		chk("dac off", dac_out_0_enable, 1'h0);
		chk("p1 oe on", p1_pin_oe, 1'h1);
		$display("test port5 done");
	endtask

	initial begin
		settle(8);
		reset = 0;
		t_gpio();
		t_p0();
		t_dbg();
		t_p3();
		t_p4();
		t_p5();
		conclude();
	end
endmodule
